// ### vmd_pkg.sv
package vmd_pkg;
   // register byte offsets, one aligned word each
   localparam logic [7:0] REG_SYNC = 8'h00;
   localparam logic [7:0] REG_LINES = 8'h04;
   localparam logic [7:0] REG_HCLK = 8'h08;
   localparam logic [7:0] REG_BPIX = 8'h0c;
   localparam logic [7:0] REG_BLIN = 8'h10;
   localparam logic [7:0] REG_APIX = 8'h14;
   localparam logic [7:0] REG_CTRL = 8'h18;
   localparam logic [7:0] REG_ALIN = 8'h1c;
   localparam logic [7:0] REG_REFCOL = 8'h20;
   localparam logic [7:0] REG_REFLIN = 8'h24;
   localparam logic [7:0] REG_REFPIX = 8'h28;
   localparam logic [7:0] REG_REFRGB = 8'h2c;
   localparam logic [7:0] REG_IRQST = 8'h30;
   localparam logic [7:0] REG_IRQMSK = 8'h34;
   // control fields
   localparam int CTRL_CLR_BIT = 0;
   localparam int CTRL_DBL_BIT = 1;
   // sync status fields
   localparam int SYNC_VPOL_BIT = 0;
   localparam int SYNC_HPOL_BIT = 1;
   localparam int SYNC_VMISS_BIT = 2;
   localparam int SYNC_HMISS_BIT = 3;
   // interrupt fields
   localparam int IRQ_W = 2;
   localparam int IRQ_MODE_BIT = 0;
   localparam int IRQ_FRAME_BIT = 1;
   // reset values
   localparam logic [IRQ_W-1:0] IRQMSK_RST = 2'h1;
   localparam logic [7:0] REFCOL_RST = 8'h10;
   localparam logic CTRL_DBL_RST = 1'b0;
   // timing
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned HS_LOSS_US = 100;
   localparam int unsigned VS_LOSS_MS = 100;
   localparam int unsigned HS_LOSS_CYC = HS_LOSS_US * CLK_MHZ;
   localparam int unsigned VS_LOSS_CYC = VS_LOSS_MS * 1000 * CLK_MHZ;
   localparam int LOSS_W = 24;
endpackage : vmd_pkg

// ### vmd_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module vmd_sync3 #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // asynchronous pins in, filtered copy out
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // three-stage chain; s1 feeds only s2
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a bit changes only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               dout[i] <= 1'b0;
            end else if (s2_r[i] == s3_r[i]) begin
               dout[i] <= s3_r[i];
            end
         end
      end
   endgenerate
endmodule : vmd_sync3
`default_nettype wire

// ### vmd_mode_detect.sv
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RQ1) report each sync polarity flag, 1 = active high, active edge falling
// (RQ2) flag vertical and horizontal sync as missing when no edges arrive
// (RQ3) report the number of lines in one full input frame
// (RQ4) report line length in reference clock periods
// (RQ5) reference is panel clock in double mode, half of it in single
// (RQ6) any flag or counter change raises the active-low interrupt
// (RQ7) writing 1 to the clear bit at address 24 clears the interrupt
// (RQ8) report back-porch blanking pixels and lines after sync end
// (RQ9) report active pixels per line and active lines per frame
// (RQ10) pixel is blanking when red, green and blue are all below threshold
// (RQ11) capture red, green, blue of the pixel at probe line and column
// (RQ12) the external converters supply the sample clock with the pixels
// (RQ13) results update once per frame, compared with last reported value
module vmd_mode_detect #(
   parameter int CW = 16,
   parameter int CDW = 8,
   parameter int unsigned HS_LOSS = vmd_pkg::HS_LOSS_CYC,
   parameter int unsigned VS_LOSS = vmd_pkg::VS_LOSS_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // video input pins
   input wire logic vert_sync_in,
   input wire logic horiz_sync_in,
   input wire logic sample_clock,
   input wire logic panel_clock,
   input wire logic [CDW-1:0] pix_red,
   input wire logic [CDW-1:0] pix_green,
   input wire logic [CDW-1:0] pix_blue,
   // interrupt
   output logic irq_n
);
   localparam int IW = 4 + 3 * CDW;

   logic [IW-1:0] inF;
   logic [3:0] edgePrev_r;
   logic [1:0] syncF;
   logic [1:0] syncPol;
   logic [1:0] syncMiss;
   logic [1:0] actEdge;
   logic vsAct;
   logic hsAct;
   logic sampleRise;
   logic pclkRise;
   logic [CDW-1:0] pixR;
   logic [CDW-1:0] pixG;
   logic [CDW-1:0] pixB;
   logic pixBlank;
   logic pixEv;
   logic refHalf_r;
   logic refTick;
   logic [CW-1:0] lineCnt_r;
   logic [CW-1:0] pixCnt_r;
   logic [CW-1:0] refCnt_r;
   logic [CW-1:0] lineClk_r;
   logic [CW-1:0] firstPix_r;
   logic [CW-1:0] lastPix_r;
   logic [CW-1:0] firstLine_r;
   logic [CW-1:0] lastLine_r;
   logic seen_r;
   logic [CW-1:0] vLines_r;
   logic [CW-1:0] hClk_r;
   logic [CW-1:0] bPix_r;
   logic [CW-1:0] aPix_r;
   logic [CW-1:0] bLin_r;
   logic [CW-1:0] aLin_r;
   logic [CW-1:0] bPixNxt;
   logic [CW-1:0] aPixNxt;
   logic [CW-1:0] bLinNxt;
   logic [CW-1:0] aLinNxt;
   logic [3:0] flagsPrev_r;
   logic modeChange;
   logic [3*CDW-1:0] refRgb_r;
   logic ctrlDbl_r;
   logic [CDW-1:0] refCol_r;
   logic [CW-1:0] refLine_r;
   logic [CW-1:0] refPix_r;
   logic [vmd_pkg::IRQ_W-1:0] irqStat_r;
   logic [vmd_pkg::IRQ_W-1:0] irqMask_r;
   logic [vmd_pkg::IRQ_W-1:0] irqEv;
   logic [vmd_pkg::IRQ_W-1:0] irqClr;
   logic accept;
   logic rdReq;
   logic wrPend_r;
   logic [7:0] wrAddr_r;
   logic [31:0] rdMux;
   logic [31:0] hrdata_r;
   logic clrWr;
   logic rdStat;

   // all pins pass the three-stage filter together
   vmd_sync3 #(.W(IW)) uSync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .din({pix_blue, pix_green, pix_red, panel_clock, sample_clock,
            horiz_sync_in, vert_sync_in}),
      .dout(inF)
   );

   assign syncF = inF[1:0];
   assign pixR = inF[4+CDW-1:4];
   assign pixG = inF[4+2*CDW-1:4+CDW];
   assign pixB = inF[4+3*CDW-1:4+2*CDW];

   // previous filtered levels for edge finding
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         edgePrev_r <= 4'h0;
      end else begin
         edgePrev_r <= inF[3:0];
      end
   end

   assign sampleRise = inF[2] & ~edgePrev_r[2]; // RQ12
   assign pclkRise = inF[3] & ~edgePrev_r[3];

   // per sync: pulse widths, polarity and loss watch (0 vertical, 1 horiz)
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         localparam int unsigned LIM = (g == 0) ? VS_LOSS : HS_LOSS;
         localparam logic [vmd_pkg::LOSS_W-1:0] LIMV =
            LIM[vmd_pkg::LOSS_W-1:0];
         logic rise;
         logic fall;
         logic [vmd_pkg::LOSS_W-1:0] run_r;
         logic [vmd_pkg::LOSS_W-1:0] hi_r;
         logic [vmd_pkg::LOSS_W-1:0] lo_r;
         logic [vmd_pkg::LOSS_W-1:0] loss_r;
         logic pol_r;
         logic miss_r;

         assign rise = syncF[g] & ~edgePrev_r[g];
         assign fall = ~syncF[g] & edgePrev_r[g];

         // run length of the current level, latched at each edge
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               run_r <= '0;
               hi_r <= '0;
               lo_r <= '0;
            end else begin
               if (rise | fall) begin
                  run_r <= {{(vmd_pkg::LOSS_W-1){1'b0}}, 1'b1};
               end else if (run_r != '1) begin
                  run_r <= run_r + 1'b1;
               end
               if (fall) begin
                  hi_r <= run_r;
               end
               if (rise) begin
                  lo_r <= run_r;
               end
            end
         end

         // shorter level is the pulse: high shorter means active high
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               pol_r <= 1'b0;
            end else begin
               pol_r <= (hi_r < lo_r); // RQ1
            end
         end

         // no edge for the loss time means the sync is absent
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               loss_r <= '0;
               miss_r <= 1'b0;
            end else begin
               if (rise | fall) begin
                  loss_r <= '0;
               end else if (loss_r != LIMV) begin
                  loss_r <= loss_r + 1'b1;
               end
               miss_r <= (loss_r == LIMV) & ~(rise | fall); // RQ2
            end
         end

         assign syncPol[g] = pol_r;
         assign syncMiss[g] = miss_r;
         // active edge ends the pulse
         assign actEdge[g] = pol_r ? fall : rise; // RQ1

         a_sync_missing: assert property (@(posedge clk_sys)
            disable iff (sys_rst) (loss_r == LIMV) && !(rise || fall)
            |=> miss_r) // RQ2
            else $error("sync loss not flagged");
         a_sync_back: assert property (@(posedge clk_sys)
            disable iff (sys_rst) (rise || fall) |=> !miss_r) // RQ2
            else $error("missing flag held after sync edge");
         a_pol_follows: assert property (@(posedge clk_sys)
            disable iff (sys_rst) fall ##1 (hi_r < lo_r) |=> pol_r) // RQ1
            else $error("polarity flag does not follow widths");
      end
   endgenerate

   assign vsAct = actEdge[0];
   assign hsAct = actEdge[1];

   // reference tick: every rising panel edge, or every second one in single mode
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         refHalf_r <= 1'b0;
      end else if (pclkRise) begin
         refHalf_r <= ~refHalf_r;
      end
   end

   assign refTick = pclkRise & (ctrlDbl_r | refHalf_r); // RQ5

   // line and pixel positions
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lineCnt_r <= '0;
         pixCnt_r <= '0;
      end else begin
         if (vsAct) begin
            lineCnt_r <= '0;
         end else if (hsAct) begin
            lineCnt_r <= lineCnt_r + 1'b1; // RQ3
         end
         if (hsAct) begin
            pixCnt_r <= '0;
         end else if (sampleRise) begin
            pixCnt_r <= pixCnt_r + 1'b1;
         end
      end
   end

   // line length in reference periods
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         refCnt_r <= '0;
         lineClk_r <= '0;
      end else begin
         if (hsAct) begin
            refCnt_r <= '0;
            lineClk_r <= refCnt_r; // RQ4
         end else if (refTick) begin
            refCnt_r <= refCnt_r + 1'b1;
         end
      end
   end

   // blanking test against the threshold colour
   assign pixBlank = (pixR < refCol_r) && (pixG < refCol_r) &&
                     (pixB < refCol_r); // RQ10
   assign pixEv = sampleRise & ~hsAct & ~vsAct & ~pixBlank;

   // extent of active video over the frame
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         firstPix_r <= '1;
         lastPix_r <= '0;
         firstLine_r <= '0;
         lastLine_r <= '0;
         seen_r <= 1'b0;
      end else if (vsAct) begin
         firstPix_r <= '1;
         lastPix_r <= '0;
         seen_r <= 1'b0;
      end else if (pixEv) begin
         seen_r <= 1'b1;
         if (pixCnt_r < firstPix_r) begin
            firstPix_r <= pixCnt_r; // RQ8
         end
         if (pixCnt_r > lastPix_r) begin
            lastPix_r <= pixCnt_r; // RQ9
         end
         if (!seen_r) begin
            firstLine_r <= lineCnt_r; // RQ8
         end
         lastLine_r <= lineCnt_r; // RQ9
      end
   end

   // new frame results; zero when no active pixel was seen
   assign bPixNxt = seen_r ? firstPix_r : '0;
   assign aPixNxt = seen_r ? CW'(lastPix_r - firstPix_r + 1'b1) : '0;
   // lines strictly between the frame start and the first active line
   assign bLinNxt = seen_r ? CW'(firstLine_r - 1'b1) : '0; // RQ8
   assign aLinNxt = seen_r ? CW'(lastLine_r - firstLine_r + 1'b1) : '0;

   // reported results, committed at each frame start
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         vLines_r <= '0;
         hClk_r <= '0;
         bPix_r <= '0;
         aPix_r <= '0;
         bLin_r <= '0;
         aLin_r <= '0;
      end else if (vsAct) begin
         vLines_r <= lineCnt_r; // RQ3 RQ13
         hClk_r <= lineClk_r; // RQ4 RQ13
         bPix_r <= bPixNxt; // RQ8
         aPix_r <= aPixNxt; // RQ9
         bLin_r <= bLinNxt; // RQ8
         aLin_r <= aLinNxt; // RQ9
      end
   end

   // change against the previously reported values
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         flagsPrev_r <= 4'h0;
      end else begin
         flagsPrev_r <= {syncMiss, syncPol};
      end
   end

   assign modeChange = ({syncMiss, syncPol} != flagsPrev_r) ||
      (vsAct && ((vLines_r != lineCnt_r) || (hClk_r != lineClk_r) ||
      (bPix_r != bPixNxt) || (aPix_r != aPixNxt) ||
      (bLin_r != bLinNxt) || (aLin_r != aLinNxt))); // RQ6 RQ13

   // probe pixel capture
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         refRgb_r <= '0;
      end else if (sampleRise && !hsAct && (lineCnt_r == refLine_r) &&
                   (pixCnt_r == refPix_r)) begin
         refRgb_r <= {pixR, pixG, pixB}; // RQ11
      end
   end

   // sticky events; a new event wins over a clear
   assign irqEv[vmd_pkg::IRQ_MODE_BIT] = modeChange;
   assign irqEv[vmd_pkg::IRQ_FRAME_BIT] = vsAct;
   assign irqClr = (rdStat | clrWr) ? '1 : '0; // RQ7

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         irqStat_r <= '0;
      end else begin
         irqStat_r <= (irqStat_r & ~irqClr) | irqEv; // RQ6
      end
   end

   assign irq_n = ~|(irqStat_r & irqMask_r); // RQ6

   // bus handshake; a read right after a write waits one cycle
   assign accept = hsel & htrans[1] & hready;
   assign rdReq = hsel & htrans[1] & ~hwrite;
   assign hreadyout = ~(wrPend_r & rdReq);
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign rdStat = accept & ~hwrite & (haddr[7:0] == vmd_pkg::REG_IRQST);
   assign clrWr = wrPend_r & (wrAddr_r == vmd_pkg::REG_CTRL) &
                  hwdata[vmd_pkg::CTRL_CLR_BIT]; // RQ7

   // address phase capture
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
      end else begin
         wrPend_r <= accept & hwrite;
         if (accept) begin
            wrAddr_r <= haddr[7:0];
         end
      end
   end

   // read selection; unmapped addresses read zero
   always_comb begin
      rdMux = 32'h0;
      if (haddr[31:8] == 24'h0) begin
         case (haddr[7:0])
            vmd_pkg::REG_SYNC: rdMux[3:0] = {syncMiss, syncPol};
            vmd_pkg::REG_LINES: rdMux[CW-1:0] = vLines_r;
            vmd_pkg::REG_HCLK: rdMux[CW-1:0] = hClk_r;
            vmd_pkg::REG_BPIX: rdMux[CW-1:0] = bPix_r;
            vmd_pkg::REG_BLIN: rdMux[CW-1:0] = bLin_r;
            vmd_pkg::REG_APIX: rdMux[CW-1:0] = aPix_r;
            vmd_pkg::REG_ALIN: rdMux[CW-1:0] = aLin_r;
            vmd_pkg::REG_CTRL: rdMux[vmd_pkg::CTRL_DBL_BIT] = ctrlDbl_r;
            vmd_pkg::REG_REFCOL: rdMux[CDW-1:0] = refCol_r;
            vmd_pkg::REG_REFLIN: rdMux[CW-1:0] = refLine_r;
            vmd_pkg::REG_REFPIX: rdMux[CW-1:0] = refPix_r;
            vmd_pkg::REG_REFRGB: rdMux[3*CDW-1:0] = refRgb_r;
            vmd_pkg::REG_IRQST: rdMux[vmd_pkg::IRQ_W-1:0] = irqStat_r;
            vmd_pkg::REG_IRQMSK: rdMux[vmd_pkg::IRQ_W-1:0] = irqMask_r;
            default: rdMux = 32'h0;
         endcase
      end
   end

   // read data registered at address phase
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         hrdata_r <= 32'h0;
      end else if (accept && !hwrite) begin
         hrdata_r <= rdMux;
      end
   end

   // register writes in the data phase
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctrlDbl_r <= vmd_pkg::CTRL_DBL_RST;
         refCol_r <= vmd_pkg::REFCOL_RST;
         refLine_r <= '0;
         refPix_r <= '0;
         irqMask_r <= vmd_pkg::IRQMSK_RST;
      end else if (wrPend_r) begin
         case (wrAddr_r)
            vmd_pkg::REG_CTRL: ctrlDbl_r <= hwdata[vmd_pkg::CTRL_DBL_BIT];
            vmd_pkg::REG_REFCOL: refCol_r <= hwdata[CDW-1:0];
            vmd_pkg::REG_REFLIN: refLine_r <= hwdata[CW-1:0];
            vmd_pkg::REG_REFPIX: refPix_r <= hwdata[CW-1:0];
            vmd_pkg::REG_IRQMSK: irqMask_r <= hwdata[vmd_pkg::IRQ_W-1:0];
            default: ctrlDbl_r <= ctrlDbl_r;
         endcase
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_clr_write;
      wrPend_r && (wrAddr_r == vmd_pkg::REG_CTRL) &&
      hwdata[vmd_pkg::CTRL_CLR_BIT];
   endsequence
   sequence s_frame_start;
      vsAct && seen_r;
   endsequence

   a_irq_level: assert property (irq_n ==
      !(|(irqStat_r & irqMask_r))) // RQ6
      else $error("interrupt pin disagrees with status and mask");
   a_change_sets: assert property (modeChange
      |=> irqStat_r[vmd_pkg::IRQ_MODE_BIT]) // RQ6
      else $error("mode change did not set status");
   a_clear_write: assert property (s_clr_write ##0 !modeChange
      |=> !irqStat_r[vmd_pkg::IRQ_MODE_BIT]) // RQ7
      else $error("clear bit write left interrupt pending");
   a_frame_lines: assert property (vsAct
      |=> vLines_r == $past(lineCnt_r)) // RQ3
      else $error("frame line count not committed");
   a_line_clocks: assert property (hsAct ##1 (!hsAct && !vsAct) [*2]
      ##1 vsAct |=> hClk_r == $past(lineClk_r, 1)) // RQ4
      else $error("line length not committed");
   a_ref_single: assert property (refTick && !ctrlDbl_r
      |-> refHalf_r) // RQ5
      else $error("single mode ticked on wrong panel edge");
   a_ref_double: assert property (pclkRise && ctrlDbl_r
      |-> refTick) // RQ5
      else $error("double mode missed a panel edge");
   a_blank_class: assert property (sampleRise && !hsAct && !vsAct &&
      pixBlank && !seen_r |=> !seen_r) // RQ10
      else $error("blanking pixel counted as active");
   a_active_pix: assert property (s_frame_start |=> aPix_r ==
      CW'($past(lastPix_r) - $past(firstPix_r) + 1'b1)) // RQ9
      else $error("active pixel count wrong");
   a_blank_pix: assert property (s_frame_start |=> (bPix_r ==
      $past(firstPix_r)) && (bLin_r == CW'($past(firstLine_r) - 1'b1)))
      // RQ8
      else $error("back porch counts wrong");
   a_ref_capture: assert property (sampleRise && !hsAct &&
      (lineCnt_r == refLine_r) && (pixCnt_r == refPix_r)
      |=> refRgb_r == $past({pixR, pixG, pixB})) // RQ11
      else $error("probe pixel not captured");
endmodule : vmd_mode_detect
`default_nettype wire

// ### vmd_placeholder_note_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### vmd_video_src.sv
`timescale 1ns/1ps
`default_nettype none
// converter-side source: syncs, sample clock, panel clock and pixels
module vmd_video_src #(
   parameter int LINES = 10,
   parameter int BLANKL = 2,
   parameter int ACTL = 5,
   parameter int BLANKP = 3,
   parameter int ACTP = 6
) (
   // control from bench
   input wire logic run,
   input wire logic vPol,
   input wire logic hPol,
   input wire logic [7:0] thr,
   // video pins
   output logic vSync,
   output logic hSync,
   output logic sampleClk,
   output logic panelClk,
   output logic [7:0] red,
   output logic [7:0] green,
   output logic [7:0] blue
);
   int ln;
   int sl;
   bit act;
   // free-running panel clock, 40 ns, kept off the system edges
   initial begin
      panelClk = 1'b0;
      #3;
      forever #20 panelClk = ~panelClk;
   end
   // line of 14 slots of 160 ns: 2 sync slots, then pixels 1..12
   initial begin
      sampleClk = 1'b0;
      ln = 1;
      #1;
      forever begin
         for (sl = 0; sl < 14; sl++) begin
            act = ln > BLANKL && ln <= BLANKL + ACTL && sl - 1 > BLANKP
               && sl - 1 <= BLANKP + ACTP;
            hSync = (run && sl < 2) ? hPol : ~hPol;
            vSync = (run && ln == LINES && sl > 7 && sl < 10) ? vPol : ~vPol;
            // first active pixel sits exactly on the threshold
            red = act ? thr + 8'(sl - BLANKP - 2) : thr - 8'h01;
            green = act ? 8'(sl - 1) : thr - 8'h01;
            blue = act ? 8'(ln) : thr - 8'h01;
            #80;
            // clock only within lines, still while idle
            sampleClk = run && sl > 1;
            #80;
            sampleClk = 1'b0;
         end
         ln = (ln == LINES) ? 1 : ln + 1;
      end
   end
endmodule : vmd_video_src
`default_nettype wire

// ### vmd_mode_detect_bench.sv
`timescale 1ns/1ps
`default_nettype none
module vmd_mode_detect_bench;
   localparam logic [7:0] THR = 8'h40;
   localparam int PLIN = 4;
   localparam int PCOL = 6;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, irq_n;
   logic [31:0] hrdata;
   logic run = 1'b0;
   logic vPol = 1'b1;
   logic hPol = 1'b1;
   logic vSync, hSync, sampleClk, panelClk;
   logic [7:0] red, green, blue;
   int badCount = 0;
   int numChecks = 0;
   int cyc = 0;
   // clock
   always #4 clk_sys = ~clk_sys;
   vmd_mode_detect #(.HS_LOSS(600), .VS_LOSS(6000)) vmd_mode_detect_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .vert_sync_in(vSync), .horiz_sync_in(hSync),
      .sample_clock(sampleClk), .panel_clock(panelClk), .pix_red(red),
      .pix_green(green), .pix_blue(blue), .irq_n(irq_n));
   vmd_video_src vmd_video_src_inst (.run(run), .vPol(vPol), .hPol(hPol),
      .thr(THR), .vSync(vSync), .hSync(hSync), .sampleClk(sampleClk),
      .panelClk(panelClk), .red(red), .green(green), .blue(blue));
   // closing report
   task automatic closeOut();
      $display("comparisons %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : closeOut
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      numChecks++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one single ahb transfer, waits on hreadyout in both phases
   task automatic busXfer(input logic wr, input logic [7:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      int n;
      logic rdy;
      n = 0;
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      // ready is looked at while settled, before the edge that uses it
      do begin
         @(negedge clk_sys);
         rdy = hreadyout;
         @(posedge clk_sys);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(negedge clk_sys);
         rdy = hreadyout;
         @(posedge clk_sys);
         n++;
      end while (rdy !== 1'b1 && n < 40);
      rd = hrdata;
      chk("bus ready", 32'h1, {31'h0, rdy});
      chk("bus answer", 32'h0, {31'h0, hresp});
   endtask : busXfer
   task automatic rdChk(input string what, input logic [7:0] a,
         input logic [31:0] exp);
      logic [31:0] d;
      busXfer(1'b0, a, 32'h0, d);
      chk(what, exp, d);
   endtask : rdChk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      busXfer(1'b1, a, d, x);
   endtask : wr
   task automatic irqChk(input logic exp);
      @(negedge clk_sys);
      chk("irq_n", {31'h0, exp}, {31'h0, irq_n});
   endtask : irqChk
   // wait k frames, then let the filter and commit settle
   task automatic frames(input int k);
      repeat (2 * k) @(vSync);
      repeat (20) @(posedge clk_sys);
   endtask : frames
   task automatic testReset();
      rdChk("refcol", vmd_pkg::REG_REFCOL, 32'h10);
      rdChk("mask", vmd_pkg::REG_IRQMSK, 32'h1);
      rdChk("ctrl", vmd_pkg::REG_CTRL, 32'h0);
      wr(8'h80, 32'hffff_ffff);
      rdChk("unmapped", 8'h80, 32'h0);
      irqChk(1'b1);
   endtask : testReset
   task automatic testMeasure();
      wr(vmd_pkg::REG_REFCOL, {24'h0, THR});
      wr(vmd_pkg::REG_REFLIN, PLIN);
      wr(vmd_pkg::REG_REFPIX, PCOL);
      run <= 1'b1;
      frames(3);
      rdChk("sync", vmd_pkg::REG_SYNC, 32'h3);
      wr(vmd_pkg::REG_LINES, 32'hffff);
      rdChk("lines", vmd_pkg::REG_LINES, 10);
      rdChk("line clocks", vmd_pkg::REG_HCLK, 14 * 160 / 80);
      rdChk("blank pix", vmd_pkg::REG_BPIX, 3);
      rdChk("blank lines", vmd_pkg::REG_BLIN, 2);
      rdChk("act pix", vmd_pkg::REG_APIX, 6);
      rdChk("act lines", vmd_pkg::REG_ALIN, 5);
      rdChk("probe", vmd_pkg::REG_REFRGB,
         {8'h0, THR + 8'(PCOL - 3), 8'(PCOL + 1), 8'(PLIN)});
      irqChk(1'b0);
   endtask : testMeasure
   task automatic testClearDouble();
      wr(vmd_pkg::REG_CTRL, 32'h1);
      irqChk(1'b1);
      frames(2);
      irqChk(1'b1);
      wr(vmd_pkg::REG_CTRL, 32'h2);
      frames(3);
      rdChk("line clocks dbl", vmd_pkg::REG_HCLK, 14 * 160 / 40);
      irqChk(1'b0);
      wr(vmd_pkg::REG_CTRL, 32'h3);
      irqChk(1'b1);
   endtask : testClearDouble
   task automatic testPolarity();
      vPol <= 1'b0;
      hPol <= 1'b0;
      frames(4);
      rdChk("sync low", vmd_pkg::REG_SYNC, 32'h0);
      irqChk(1'b0);
      wr(vmd_pkg::REG_CTRL, 32'h3);
   endtask : testPolarity
   task automatic testFrameIrq();
      wr(vmd_pkg::REG_IRQMSK, 32'h2);
      frames(1);
      irqChk(1'b0);
      rdChk("status", vmd_pkg::REG_IRQST, 32'h2);
      irqChk(1'b1);
      wr(vmd_pkg::REG_IRQMSK, 32'h0);
      frames(1);
      irqChk(1'b1);
      wr(vmd_pkg::REG_IRQMSK, 32'h1);
   endtask : testFrameIrq
   task automatic testMissing();
      logic [31:0] d;
      wr(vmd_pkg::REG_CTRL, 32'h3);
      run <= 1'b0;
      repeat (6700) @(posedge clk_sys);
      busXfer(1'b0, vmd_pkg::REG_SYNC, 32'h0, d);
      chk("missing", 32'h3, {30'h0, d[3:2]});
      irqChk(1'b0);
      run <= 1'b1;
      frames(3);
      rdChk("present", vmd_pkg::REG_SYNC, 32'h0);
   endtask : testMissing
   // hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         badCount++;
         closeOut();
      end
   end
   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      testReset();
      testMeasure();
      testClearDouble();
      testPolarity();
      testFrameIrq();
      testMissing();
      closeOut();
   end
endmodule : vmd_mode_detect_bench
`default_nettype wire
